// File: hdl/mpus_debounce.sv
`timescale 1ns/100ps
module mpus_debounce
   import mpus_pkg::*;
#(
   parameter int COUNT = DEBOUNCE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);

   logic [TMR_W-1:0] cnt;

   // ****************************************************************
   // Output follows the input only after it stood stable COUNT cycles
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         dout <= 1'b1;
      end else if (din == dout) begin
         cnt <= '0;
      end else if (cnt >= TMR_W'(COUNT - 1)) begin
         cnt <= '0;
         dout <= din;
      end else begin
         cnt <= cnt + TMR_W'(1);
      end
   end

endmodule

// File: hdl/mpus_pkg.sv
package mpus_pkg;

   // ****************************************************************
   // Clock
   // ****************************************************************
   localparam int CLK_FREQ_KHZ = 40000;

   // ****************************************************************
   // Timing, times in microseconds, counts in clk_sys cycles
   // ****************************************************************
   localparam int SETTLE_TIME_US = 10000;
   localparam int SETTLE_CYC = (SETTLE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
   localparam int DEBOUNCE_TIME_US = 20000;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
   localparam int RESET_HOLD_TIME_US = 1000;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
   localparam int TMR_W = 20;

   // ****************************************************************
   // Reset values and bit indices of the synchronisers
   // ****************************************************************
   localparam logic [2:0] SYNC_RST = 3'h6;
   localparam int SYNC_PWR = 0;
   localparam int SYNC_REQ = 1;
   localparam int SYNC_BTN = 2;

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_OFF,
      ST_OWN,
      ST_BTN,
      ST_CARR,
      ST_RUN,
      ST_SUSP,
      ST_RHOLD,
      ST_SOFF
   } mpus_state_e;

endpackage

// File: hdl/mpus_sequencer.sv
// What this block does
// - Own power circuits stay off while the input power indication is low and come on only once it is high.
// - After own power is up, a power-button press is awaited when the carrier has a button.
// - Carrier power is enabled by raising the supply enable and the standby line together after the button step.
// - The reset output is released only after carrier power is on, as the last step of power-up.
// - A low input power indication means the input voltage is not ready or out of range.
// - The carrier supply enable is active high and is raised only with all own supplies good.
// - The standby output is active low and goes low on entry into suspend.
// - A low level on the open-drain reset request input resets the module.
// - The reset output stays low during the whole power-up sequence.
// - The open-drain power button input wakes from or shuts down into soft-off.
`timescale 1ns/100ps
module mpus_sequencer
   import mpus_pkg::*;
#(
   parameter int SETTLE_COUNT = SETTLE_CYC,
   parameter int DEBOUNCE_COUNT = DEBOUNCE_CYC,
   parameter int RESET_HOLD_COUNT = RESET_HOLD_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic input_power_bad_n,
   input wire logic reset_request_n,
   input wire logic power_button_input_n,
   input wire logic button_required,
   input wire logic own_supplies_good,
   input wire logic suspend_request,
   output logic own_supply_enable,
   output logic carrier_supply_enable,
   output logic carrier_standby_n,
   output logic reset_out_n,
   output logic power_button_event_n
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic pwr_ok;
   logic rst_req_n;
   logic btn_db;
   logic btn_db_prev;
   logic btn_press;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               sync_a[gi] <= SYNC_RST[gi];
               sync_b[gi] <= SYNC_RST[gi];
            end else begin
               sync_a[gi] <= (gi == SYNC_PWR) ? input_power_bad_n :
                             (gi == SYNC_REQ) ? reset_request_n : power_button_input_n;
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   assign pwr_ok = sync_b[SYNC_PWR];
   assign rst_req_n = sync_b[SYNC_REQ];

   // Button is filtered before any edge is taken from it
   mpus_debounce #(
      .COUNT(DEBOUNCE_COUNT)
   ) u_btn_debounce (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .din(sync_b[SYNC_BTN]),
      .dout(btn_db)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         btn_db_prev <= 1'b1;
      end else begin
         btn_db_prev <= btn_db;
      end
   end

   assign btn_press = btn_db_prev & ~btn_db;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   mpus_state_e state;
   mpus_state_e next_state;
   logic [TMR_W-1:0] timer;
   logic timer_done;

   assign timer_done = (timer == '0);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_OFF: begin
            next_state = ST_OWN;
         end
         ST_OWN: begin
            if (own_supplies_good) begin
               next_state = button_required ? ST_BTN : ST_CARR;
            end
         end
         ST_BTN: begin
            if (btn_press) begin
               next_state = ST_CARR;
            end
         end
         ST_CARR: begin
            if (timer_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!rst_req_n) begin
               next_state = ST_RHOLD;
            end else if (btn_press) begin
               next_state = ST_SOFF;
            end else if (suspend_request) begin
               next_state = ST_SUSP;
            end
         end
         ST_SUSP: begin
            if (!rst_req_n) begin
               next_state = ST_RHOLD;
            end else if (btn_press || !suspend_request) begin
               next_state = ST_RUN;
            end
         end
         ST_RHOLD: begin
            if (timer_done && rst_req_n) begin
               next_state = ST_RUN;
            end
         end
         ST_SOFF: begin
            if (btn_press) begin
               next_state = ST_CARR;
            end
         end
      endcase
      // Loss of own supplies restarts from the own power step
      if (state != ST_OFF && state != ST_OWN && !own_supplies_good) begin
         next_state = ST_OWN;
      end
      // Bad input power overrides everything
      if (!pwr_ok) begin
         next_state = ST_OFF;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Settle and reset hold timer
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timer <= '0;
      end else if (state != next_state) begin
         if (next_state == ST_CARR) begin
            timer <= TMR_W'(SETTLE_COUNT - 1);
         end else begin
            timer <= TMR_W'(RESET_HOLD_COUNT - 1);
         end
      end else if (!timer_done) begin
         timer <= timer - TMR_W'(1);
      end
   end

   // ****************************************************************
   // Output flops, decoded from the next state, the button event from btn_press
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         own_supply_enable <= 1'b0;
      end else begin
         own_supply_enable <= (next_state != ST_OFF);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         carrier_supply_enable <= 1'b0;
         carrier_standby_n <= 1'b0;
      end else begin
         carrier_supply_enable <= (next_state == ST_CARR) || (next_state == ST_RUN) ||
                                  (next_state == ST_SUSP) || (next_state == ST_RHOLD);
         carrier_standby_n <= (next_state == ST_CARR) || (next_state == ST_RUN) ||
                              (next_state == ST_RHOLD);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reset_out_n <= 1'b0;
      end else begin
         reset_out_n <= (next_state == ST_RUN) || (next_state == ST_SUSP);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         power_button_event_n <= 1'b1;
      end else begin
         power_button_event_n <= ~btn_press;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_power_bad;
      !pwr_ok;
   endsequence

   sequence s_all_off;
      !own_supply_enable && !carrier_supply_enable && !reset_out_n;
   endsequence

   sequence s_settled;
      carrier_supply_enable && carrier_standby_n && !reset_out_n;
   endsequence

   off_when_bad_a: assert property (s_power_bad |=> s_all_off)
      else $error("Supplies or reset active while input power is bad");

   own_before_carrier_a: assert property (
      $rose(carrier_supply_enable) |-> own_supply_enable && $past(own_supplies_good))
      else $error("Carrier supply enabled without own supplies good");

   button_gate_a: assert property (
      $rose(carrier_supply_enable) && $past(button_required) |-> $past(btn_press))
      else $error("Carrier power enabled without a button press");

   carrier_pair_a: assert property (
      $rose(carrier_supply_enable) |-> carrier_standby_n)
      else $error("Supply enable and standby did not rise together");

   reset_after_power_a: assert property (
      $rose(reset_out_n) |-> $past(carrier_supply_enable) && $past(carrier_standby_n))
      else $error("Reset released before carrier power was on");

   settle_hold_a: assert property (
      $rose(carrier_supply_enable) && !reset_out_n |-> s_settled [*2])
      else $error("Reset released without a settle interval");

   standby_entry_a: assert property (
      $fell(carrier_standby_n) && carrier_supply_enable |-> reset_out_n && $past(suspend_request))
      else $error("Standby asserted without a suspend request");

   reset_request_a: assert property (
      !rst_req_n && (state == ST_RUN) && pwr_ok && own_supplies_good |=> !reset_out_n [*2])
      else $error("Reset request did not hold the reset output");

   button_shutdown_a: assert property (
      btn_press && (state == ST_RUN) && rst_req_n && pwr_ok && own_supplies_good
      |=> !carrier_supply_enable && !reset_out_n && own_supply_enable)
      else $error("Button did not enter soft-off");

   button_wake_a: assert property (
      btn_press && (state == ST_SOFF) && pwr_ok && own_supplies_good |=> s_settled)
      else $error("Button did not wake from soft-off");

   sync_delay_a: assert property (
      $fell(rst_req_n) |-> $past(reset_request_n, 2) == 1'b0)
      else $error("Reset request bypassed the synchroniser");

   event_pulse_a: assert property (!power_button_event_n |=> power_button_event_n)
      else $error("Button event pulse longer than one cycle");

   standby_powered_a: assert property (carrier_standby_n |-> carrier_supply_enable)
      else $error("Standby line high with carrier supply off");

   reset_powered_a: assert property (reset_out_n |-> carrier_supply_enable)
      else $error("Reset released with carrier supply off");

   own_first_a: assert property (!own_supply_enable |-> !carrier_supply_enable)
      else $error("Carrier supply on with own supplies off");

   button_wait_a: assert property ((state == ST_BTN) && !btn_press |=> !carrier_supply_enable)
      else $error("Carrier supply enabled while waiting for the button");

endmodule

// File: verification/mpus_carrier_model.sv
`timescale 1ns/100ps
module mpus_carrier_model #(
   parameter int STABLE_COUNT = 5
) (
   input wire logic clk_sys,
   input wire logic mains_on,
   input wire logic press_button,
   input wire logic request_reset,
   input wire logic carrier_supply_enable,
   input wire logic carrier_standby_n,
   output logic input_power_bad_n,
   output logic reset_request_n,
   output logic power_button_input_n,
   output logic carrier_rail_on
);
   int stable_cnt = 0;

   always @(posedge clk_sys) begin
      stable_cnt <= mains_on ? stable_cnt + 1 : 0;
   end

   // Power indication stays low until the input has been steady for a while
   assign input_power_bad_n = mains_on && (stable_cnt >= STABLE_COUNT);
   // Open-drain lines with pull-ups: high whenever nobody pulls them low
   assign reset_request_n = request_reset ? 1'b0 : 1'b1;
   assign power_button_input_n = press_button ? 1'b0 : 1'b1;
   // Carrier rails that are not needed in standby are switched off
   assign carrier_rail_on = carrier_supply_enable & carrier_standby_n;
endmodule

// File: verification/mpus_sequencer_tb_top.sv
`timescale 1ns/100ps
module mpus_sequencer_tb_top
   import mpus_pkg::*;
   ;
   localparam int SETTLE = 4;
   localparam int K_OWN = 0, K_CARR = 1, K_STBY = 2, K_RST = 3;
   logic clk_sys = 0, rst_n = 0, button_required = 0, own_supplies_good = 1, suspend_request = 0;
   logic mains_on = 0, press_button = 0, request_reset = 0;
   logic input_power_bad_n, reset_request_n, power_button_input_n, carrier_rail_on;
   logic own_supply_enable, carrier_supply_enable, carrier_standby_n, reset_out_n, power_button_event_n;
   int n_mismatch = 0, n_checks = 0, n_events = 0;

   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (power_button_event_n === 1'b0) n_events <= n_events + 1;

   mpus_sequencer #(.SETTLE_COUNT(SETTLE), .DEBOUNCE_COUNT(3), .RESET_HOLD_COUNT(4)) u_mpus_sequencer (
      .clk_sys(clk_sys), .rst_n(rst_n), .input_power_bad_n(input_power_bad_n),
      .reset_request_n(reset_request_n), .power_button_input_n(power_button_input_n),
      .button_required(button_required), .own_supplies_good(own_supplies_good),
      .suspend_request(suspend_request), .own_supply_enable(own_supply_enable),
      .carrier_supply_enable(carrier_supply_enable), .carrier_standby_n(carrier_standby_n),
      .reset_out_n(reset_out_n), .power_button_event_n(power_button_event_n));

   mpus_carrier_model u_mpus_carrier_model (
      .clk_sys(clk_sys), .mains_on(mains_on), .press_button(press_button),
      .request_reset(request_reset), .carrier_supply_enable(carrier_supply_enable),
      .carrier_standby_n(carrier_standby_n), .input_power_bad_n(input_power_bad_n),
      .reset_request_n(reset_request_n), .power_button_input_n(power_button_input_n),
      .carrier_rail_on(carrier_rail_on));

   task step(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   task check_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t output level mismatch", $time);
      end
   endtask

   function logic pick(input int k);
      case (k)
         K_OWN: return own_supply_enable;
         K_CARR: return carrier_supply_enable;
         K_STBY: return carrier_standby_n;
         default: return reset_out_n;
      endcase
   endfunction

   // Polls once a cycle, then judges the level reached
   task wait_for(input int k, input logic v, input int max);
      for (int i = 0; i < max && pick(k) !== v; i++) step(1);
      check_bit(pick(k), v);
   endtask

   task press(input int n);
      press_button = 1;
      step(n);
      press_button = 0;
      step(12);
   endtask

   task power_up_plain;
      mains_on = 1;
      step(3);
      check_bit(own_supply_enable, 1'b0);
      wait_for(K_OWN, 1'b1, 20);
      check_bit(reset_out_n, 1'b0);
      wait_for(K_CARR, 1'b1, 5);
      check_bit(carrier_standby_n, 1'b1);
      step(SETTLE - 1);
      check_bit(reset_out_n, 1'b0);
      wait_for(K_RST, 1'b1, 3);
      check_bit(carrier_rail_on, 1'b1);
   endtask

   task suspend_cycle;
      suspend_request = 1;
      wait_for(K_STBY, 1'b0, 4);
      check_bit(carrier_supply_enable, 1'b1);
      check_bit(reset_out_n, 1'b1);
      suspend_request = 0;
      wait_for(K_STBY, 1'b1, 4);
   endtask

   task reset_request;
      request_reset = 1;
      wait_for(K_RST, 1'b0, 6);
      step(10);
      check_bit(reset_out_n, 1'b0);
      check_bit(carrier_supply_enable, 1'b1);
      request_reset = 0;
      wait_for(K_RST, 1'b1, 8);
   endtask

   task button_cycle;
      int e;
      e = n_events;
      press(1);
      check_bit(n_events == e, 1'b1);
      check_bit(carrier_supply_enable, 1'b1);
      press(8);
      check_bit(n_events == e + 1, 1'b1);
      wait_for(K_CARR, 1'b0, 10);
      check_bit(reset_out_n, 1'b0);
      check_bit(own_supply_enable, 1'b1);
      press(8);
      wait_for(K_CARR, 1'b1, 10);
      wait_for(K_RST, 1'b1, 10);
   endtask

   task power_fail_and_button_start;
      mains_on = 0;
      wait_for(K_OWN, 1'b0, 6);
      check_bit(carrier_supply_enable, 1'b0);
      check_bit(reset_out_n, 1'b0);
      button_required = 1;
      mains_on = 1;
      wait_for(K_OWN, 1'b1, 20);
      step(15);
      check_bit(carrier_supply_enable, 1'b0);
      press(8);
      wait_for(K_CARR, 1'b1, 10);
      wait_for(K_RST, 1'b1, 10);
   endtask

   task own_supply_loss;
      button_required = 0;
      own_supplies_good = 0;
      wait_for(K_CARR, 1'b0, 4);
      check_bit(reset_out_n, 1'b0);
      own_supplies_good = 1;
      wait_for(K_CARR, 1'b1, 6);
      wait_for(K_RST, 1'b1, 10);
   endtask

   task results;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      step(2);
      rst_n = 1;
      step(1);
      power_up_plain();
      suspend_cycle();
      reset_request();
      button_cycle();
      power_fail_and_button_start();
      own_supply_loss();
      results();
   end

   // Whole sequence needs under two hundred cycles
   initial begin
      #(25 * 2000);
      n_mismatch++;
      results();
   end
endmodule
